// ### src/iscd_params.svh
// Constants for the start-condition generator with collision detection.
// Assumes inclusion by the package file and the start generator module.
`ifndef ISCD_PARAMS_SVH
`define ISCD_PARAMS_SVH

`define ISCD_BAUD_W 8
`define ISCD_BAUD_RESET 8'h04
`define ISCD_CNT_ZERO 8'h00
`define ISCD_CNT_ONE 8'h01

`endif

// ### src/iscd_pkg.sv
// Types for the start-condition generator.
// Assumes iscd_params.svh is on the include path.
`include "iscd_params.svh"

package iscd_pkg;

    typedef enum logic [2:0] {
        ISCD_IDLE = 3'h0,
        ISCD_WAIT_HIGH = 3'h1,
        ISCD_FIRST = 3'h2,
        ISCD_SECOND = 3'h3,
        ISCD_DONE = 3'h4
    } iscd_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } iscd_bus_t;

endpackage

// ### src/iscd_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to clk_in.
`timescale 1ns/100ps

module iscd_sync (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // Released lines idle high
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// ### src/iscd_start_gen.sv
// I2C master start-condition generator with bus-collision detection.
// Assumes open-drain SDA/SCL pins outside; the pins are sampled through
// two-flop synchronisers, outputs are enables that pull the line low.
// Pin levels reach the sequencer two cycles after they change.
`timescale 1ns/100ps
`include "iscd_params.svh"

// Function
// - Either line low at request is collision
// - SCL low before own SDA low collides
// - Collision aborts, flags, resets unit idle
// - SDA high loads counter, counts down
// - SDA low in count: reset, drive early
// - Count expiry drives SDA, reloads counter
// - SCL low in second count: no collision
// - Second count zero drives SCL low
module iscd_start_gen
    import iscd_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_req_in,
    input wire logic [`ISCD_BAUD_W-1:0] baud_in,
    input wire logic flag_clear_in,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic scl_out,
    output logic scl_oe_out,
    output logic busy_out,
    output logic start_done_out,
    output logic bus_collision_flag_out,
    output logic unit_reset_out
);

    iscd_bus_t pins;
    logic sda_sync;
    logic scl_sync;
    iscd_state_t state_q;
    iscd_state_t state_d;
    logic [`ISCD_BAUD_W-1:0] baud_q;
    logic [`ISCD_BAUD_W-1:0] baud_d;
    logic [`ISCD_BAUD_W-1:0] cnt_q;
    logic [`ISCD_BAUD_W-1:0] cnt_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic scl_oe_q;
    logic scl_oe_d;
    logic done_q;
    logic done_d;
    logic flag_q;
    logic flag_d;
    logic unit_rst_q;
    logic unit_rst_d;
    logic collide;
    logic hold_off_q;
    logic hold_off_d;
    logic busy_q;
    logic busy_d;

    iscd_sync u_sync_sda (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(sda_in),
        .sync_out(sda_sync)
    );

    iscd_sync u_sync_scl (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .async_in(scl_in),
        .sync_out(scl_sync)
    );

    // One driver for the carrier of both synced levels
    always_comb begin
        pins.sda = sda_sync;
        pins.scl = scl_sync;
    end

    // Sequencer: take, two countdowns, abort
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sda_oe_d = sda_oe_q;
        scl_oe_d = scl_oe_q;
        done_d = 1'b0;
        unit_rst_d = 1'b0;
        collide = 1'b0;
        // Setting only sampled while idle so a sequence sees one value
        baud_d = (state_q == ISCD_IDLE) ? baud_in : baud_q;
        case (state_q)
            ISCD_IDLE: begin
                sda_oe_d = 1'b0;
                scl_oe_d = 1'b0;
                // A request still held after an abort is not retaken
                if (start_req_in && !hold_off_q) begin
                    if (!pins.sda || !pins.scl) begin
                        collide = 1'b1;
                    end else begin
                        state_d = ISCD_WAIT_HIGH;
                    end
                end
            end
            ISCD_WAIT_HIGH: begin
                // SDA held low by another party: keep waiting
                if (!pins.scl) begin
                    collide = 1'b1;
                end else if (pins.sda) begin
                    cnt_d = baud_q;
                    state_d = ISCD_FIRST;
                end
            end
            ISCD_FIRST: begin
                if (!pins.scl) begin
                    collide = 1'b1;
                end else if (!pins.sda ||
                             cnt_q <= `ISCD_CNT_ONE) begin
                    // Early assert on low SDA skips the rest of count
                    sda_oe_d = 1'b1;
                    cnt_d = baud_q;
                    state_d = ISCD_SECOND;
                end else begin
                    cnt_d = cnt_q - `ISCD_CNT_ONE;
                end
            end
            ISCD_SECOND: begin
                // SCL is not watched here: another master may win
                // the race and arbitration follows in the address
                if (cnt_q <= `ISCD_CNT_ONE) begin
                    scl_oe_d = 1'b1;
                    cnt_d = `ISCD_CNT_ZERO;
                    done_d = 1'b1;
                    state_d = ISCD_DONE;
                end else begin
                    cnt_d = cnt_q - `ISCD_CNT_ONE;
                end
            end
            ISCD_DONE: begin
                // Hold both lines low until the request drops
                if (!start_req_in) begin
                    sda_oe_d = 1'b0;
                    scl_oe_d = 1'b0;
                    state_d = ISCD_IDLE;
                end
            end
            default: begin
                state_d = ISCD_IDLE;
            end
        endcase
        if (collide) begin
            state_d = ISCD_IDLE;
            sda_oe_d = 1'b0;
            scl_oe_d = 1'b0;
            cnt_d = `ISCD_CNT_ZERO;
            unit_rst_d = 1'b1;
        end
    end

    // New collision beats a clear in the same cycle
    always_comb begin
        flag_d = collide | (flag_q & ~flag_clear_in);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Without the hold-off a held request would abort every cycle
    always_comb begin
        hold_off_d = collide | (hold_off_q & start_req_in);
        busy_d = (state_d != ISCD_IDLE);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            hold_off_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            hold_off_q <= hold_off_d;
            busy_q <= busy_d;
        end
    end

    // Sequencer state, counter and line enables
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= ISCD_IDLE;
            cnt_q <= `ISCD_CNT_ZERO;
            baud_q <= `ISCD_BAUD_RESET;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            done_q <= 1'b0;
            unit_rst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            baud_q <= baud_d;
            sda_oe_q <= sda_oe_d;
            scl_oe_q <= scl_oe_d;
            done_q <= done_d;
            unit_rst_q <= unit_rst_d;
        end
    end

    // Open drain: only the enables move, the driven value stays low
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe_out = sda_oe_q;
    assign scl_oe_out = scl_oe_q;
    assign busy_out = busy_q;
    assign start_done_out = done_q;
    assign bus_collision_flag_out = flag_q;
    assign unit_reset_out = unit_rst_q;

endmodule

// ### testbench/iscd_start_gen_asserts.sv
// Port checks for the start generator.
// Assumes a bind from the bench top; one clock domain.
`timescale 1ns/100ps

module iscd_start_gen_asserts (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] baud_in,
    input wire logic flag_clear_in,
    input wire logic scl_in,
    input wire logic sda_oe_out,
    input wire logic scl_oe_out,
    input wire logic busy_out,
    input wire logic start_done_out,
    input wire logic bus_collision_flag_out,
    input wire logic unit_reset_out
);
    logic [7:0] bq;
    logic [7:0] gap;
    // Count setting is frozen at the take, like the design
    always_ff @(posedge clk_in) begin
        if (!busy_out) bq <= baud_in;
        gap <= !sda_oe_out ? 8'h00 : gap + {7'h00, !scl_oe_out};
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    AST_GAP: assert property ($rose(scl_oe_out) |->
        gap == (bq > 8'h01 ? bq : 8'h01)) else $error("scl gap wrong");
    AST_DONE: assert property ($rose(scl_oe_out) |->
        start_done_out && sda_oe_out) else $error("done not with scl");
    AST_ABORT: assert property (unit_reset_out |->
        bus_collision_flag_out && !sda_oe_out && !scl_oe_out)
        else $error("abort incomplete");
    AST_PULSE: assert property (unit_reset_out |=> !unit_reset_out)
        else $error("unit reset too long");
    AST_CAUSE: assert property ($rose(bus_collision_flag_out) |->
        unit_reset_out) else $error("flag without reset");
    AST_STICKY: assert property (bus_collision_flag_out &&
        !flag_clear_in |=> bus_collision_flag_out) else $error("flag lost");
    AST_SECOND: assert property (sda_oe_out && !scl_oe_out |=>
        !unit_reset_out) else $error("collision in second count");
    AST_WAIT: assert property ($rose(busy_out) |->
        !sda_oe_out ##1 !sda_oe_out) else $error("sda low too soon");
    cover property (start_done_out);
    cover property (unit_reset_out);
    cover property (sda_oe_out && !scl_oe_out && !scl_in);
endmodule

// ### testbench/iscd_bus_model.sv
// Far side: other masters and slaves on the shared lines.
// Assumes pulled-up open-drain lines; any party pulling wins.
`timescale 1ns/100ps

module iscd_bus_model
    import iscd_pkg::*;
(
    input wire logic sda_oe_in,
    input wire logic scl_oe_in,
    input wire logic sda_pull_in,
    input wire logic scl_pull_in,
    input wire logic clocking_in,
    output iscd_bus_t line_out
);
    logic link_low;
    // Rival clock, 80 ns, off-phase; parked high when idle
    initial begin
        link_low = 1'b0;
        #17;
        forever #40 link_low = clocking_in ? ~link_low : 1'b0;
    end
    assign line_out.sda = ~(sda_oe_in | sda_pull_in);
    assign line_out.scl = ~(scl_oe_in | scl_pull_in | link_low);
endmodule

// ### testbench/i2c_start_collision_detect_test.sv
// Bench for the start generator with collision detection.
// Assumes the bus model and checker files compile first.
`timescale 1ns/100ps

module i2c_start_collision_detect_test
    import iscd_pkg::*;
;
    logic clk_in, rst_n_in, req, clr, o_sda, o_scl, run;
    logic sda_oe, scl_oe, busy, done, flag, urst, sdv, scv;
    logic [7:0] baud;
    logic [2:0] outs;
    iscd_bus_t line;
    int miscompares, checks, n;
    assign outs = {urst, scl_oe, sda_oe};
    iscd_start_gen dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .start_req_in(req), .baud_in(baud), .flag_clear_in(clr),
        .sda_in(line.sda), .scl_in(line.scl), .sda_out(sdv),
        .sda_oe_out(sda_oe), .scl_out(scv), .scl_oe_out(scl_oe),
        .busy_out(busy), .start_done_out(done),
        .bus_collision_flag_out(flag), .unit_reset_out(urst));
    iscd_bus_model bus (.sda_oe_in(sda_oe), .scl_oe_in(scl_oe),
        .sda_pull_in(o_sda), .scl_pull_in(o_scl), .clocking_in(run),
        .line_out(line));
    task results;
        if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (e !== g) begin
            miscompares++;
            $display("ERROR %s exp %h got %h", nm, e, g);
        end
    endtask
    task until_hi(input int w);
        n = 0;
        do begin
            @(posedge clk_in);
            #1;
            n++;
        end while (outs[w] !== 1'b1 && n < 200);
        if (n >= 200) begin
            miscompares++;
            results;
        end
    endtask
    // Flag cleared late: a retake right after abort may collide again
    task drop;
        @(posedge clk_in);
        {req, o_sda, o_scl, run} <= 4'h0;
        repeat (5) @(posedge clk_in);
        clr <= 1'b1;
        @(posedge clk_in) clr <= 1'b0;
        @(posedge clk_in);
        #1;
        chk("idle", 8'h00, {4'h0, flag, sda_oe, scl_oe, busy});
    endtask
    task t_plain;
        @(posedge clk_in);
        baud <= 8'h03;
        req <= 1'b1;
        until_hi(0);
        chk("sda_delay", 8'h05, n[7:0]);
        until_hi(1);
        chk("scl_delay", 8'h03, n[7:0]);
        chk("done", 8'h01, {7'h00, done});
        chk("drive_val", 8'h00, {6'h00, sdv, scv});
        drop;
    endtask
    task t_busy_at_req;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_in);
            o_sda <= (k == 0);
            o_scl <= (k == 1);
            repeat (3) @(posedge clk_in);
            req <= 1'b1;
            until_hi(2);
            chk("req_coll", 8'h01, {7'h00, flag});
            drop;
        end
    endtask
    task t_scl_clock;
        @(posedge clk_in);
        baud <= 8'h14;
        run <= 1'b1;
        req <= 1'b1;
        until_hi(2);
        chk("scl_coll", 8'h01, {7'h00, flag});
        drop;
    endtask
    task t_early;
        @(posedge clk_in);
        baud <= 8'h08;
        req <= 1'b1;
        repeat (4) @(posedge clk_in);
        o_sda <= 1'b1;
        until_hi(0);
        chk("early", 8'h03, n[7:0]);
        @(posedge clk_in) o_scl <= 1'b1;
        until_hi(1);
        chk("no_coll", 8'h00, {7'h00, flag});
        drop;
    endtask
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    initial begin
        {rst_n_in, req, clr, o_sda, o_scl, run} = 6'h00;
        baud = 8'h04;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        t_plain;
        t_busy_at_req;
        t_scl_clock;
        t_early;
        results;
    end
endmodule

bind iscd_start_gen iscd_start_gen_asserts chk (.*);
